// file: dasf_attach_fsm.sv
// attach state machine of a debug probe at a target receptacle
`timescale 1ns/1ps
`include "dasf_consts.svh"
module dasf_attach_fsm
  import dasf_pkg::*;
#(
  parameter logic [1:0]  PROBE_ROLE     = `DASF_ROLE_DUAL,
  parameter bit          FAULT_SUPPORT  = 1'b1,
  parameter bit          HAS_DISABLED   = 1'b0,
  parameter int unsigned FAULT_CYC      = `DASF_FAULT_CYC,
  parameter int unsigned SHORT_DEB_CYC  = `DASF_SHORT_DEB_CYC,
  parameter int unsigned ATTACH_DEB_CYC = `DASF_ATTACH_DEB_CYC,
  parameter int unsigned SINK_SEES_OPEN_CYC   = `DASF_SINK_SEES_OPEN_CYC
)
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] cc1_level,
  input  wire logic [1:0] cc2_level,
  input  wire logic       vbus_present,
  input  wire logic       orient_known,
  input  wire logic       fault_req,
  input  wire logic       role_swap_req,
  output logic      [6:0] conn_state,
  output logic            cc1_pulldown,
  output logic            cc2_pulldown,
  output logic            cc1_pullup,
  output logic            cc2_pullup,
  output logic            vbus_drive,
  output logic            vconn_drive,
  output logic            debug_connect,
  output logic            pd_enable,
  output logic            src_try_start
);
  typedef struct packed {
    logic [1:0]  cc1_m;
    logic [1:0]  cc2_m;
    logic [1:0]  cc1_s;
    logic [1:0]  cc2_s;
    logic        vb_m;
    logic        vb_s;
    dasf_state_t fsm;
    logic        cond_q;
    logic        cc1_pd;
    logic        cc2_pd;
    logic        cc1_pu;
    logic        cc2_pu;
    logic        dbg;
    logic        pd;
    logic        try_p;
  } dasf_st_t;

  dasf_st_t st;
  dasf_st_t next_st;
  dasf_timer_if tif ();

  dasf_timer u_timer (
    .clk   (clk),
    .rst_n (rst_n),
    .tif   (tif)
  );

  logic both_up;
  logic any_open;
  logic cond_now;
  logic tmr_done;
  logic dual;
  logic snk_only;
  dasf_state_t idle_st;

  assign dual     = (PROBE_ROLE == `DASF_ROLE_DUAL);
  assign snk_only = (PROBE_ROLE == `DASF_ROLE_SINK);
  assign idle_st  = snk_only ? DASF_SNK_IDLE : DASF_SRC_IDLE;
  // matching pull-ups required on both lines
  assign both_up  = (st.cc1_s == `DASF_CC_PULLUP) && (st.cc2_s == `DASF_CC_PULLUP);
  assign any_open = (st.cc1_s == `DASF_CC_OPEN) || (st.cc2_s == `DASF_CC_OPEN);

  // qualifying condition per state; a change restarts the timer
  always_comb begin
    case (st.fsm)
      DASF_SNK_IDLE: cond_now = any_open;
      DASF_SNK_WAIT: cond_now = any_open;
      default:       cond_now = 1'b0;
    endcase
  end

  // stale done from before a condition change is ignored
  assign tmr_done = tif.done && (cond_now == st.cond_q);

  // limit follows the state being entered, loaded on a state change
  always_comb begin
    case (next_st.fsm)
      DASF_FAULT:    tif.limit = FAULT_CYC[19:0];
      DASF_SNK_IDLE: tif.limit = SINK_SEES_OPEN_CYC[19:0];
      DASF_SNK_WAIT: tif.limit = any_open ? SHORT_DEB_CYC[19:0] : ATTACH_DEB_CYC[19:0];
      default:       tif.limit = FAULT_CYC[19:0];
    endcase
  end

  always_comb begin
    next_st       = st;
    next_st.cc1_m = cc1_level;
    next_st.cc2_m = cc2_level;
    next_st.cc1_s = st.cc1_m;
    next_st.cc2_s = st.cc2_m;
    next_st.vb_m  = vbus_present;
    next_st.vb_s  = st.vb_m;
    next_st.cond_q = cond_now;
    next_st.try_p = 1'b0;
    tif.restart   = (cond_now != st.cond_q);
    case (st.fsm)
      DASF_FAULT: begin
        if (tmr_done) begin
          next_st.fsm = idle_st;
        end
      end
      DASF_SNK_IDLE: begin
        if (both_up) begin
          next_st.fsm = DASF_SNK_WAIT;
        end else if (dual && (role_swap_req || (any_open && tmr_done))) begin
          next_st.fsm = DASF_SRC_IDLE;
        end
      end
      DASF_SNK_WAIT: begin
        if (any_open && tmr_done) begin
          next_st.fsm = dual ? DASF_SRC_IDLE : DASF_SNK_IDLE;
        end else if (!any_open && tmr_done && st.vb_s) begin
          next_st.fsm   = dual ? DASF_SRC_TRY : DASF_SNK_ATT;
          next_st.try_p = dual;
        end
      end
      DASF_SNK_ATT: begin
        if (!st.vb_s) begin
          next_st.fsm = DASF_SNK_IDLE;
        end
      end
      default: begin
      end
    endcase
    if (fault_req && st.fsm != DASF_FAULT) begin
      if (FAULT_SUPPORT) begin
        next_st.fsm = DASF_FAULT;
      end else begin
        next_st.fsm = HAS_DISABLED ? DASF_DISABLED : idle_st;
      end
    end
    if (next_st.fsm != st.fsm) begin
      tif.restart = 1'b1;
    end
    next_st.cc1_pd = (next_st.fsm == DASF_SNK_IDLE) || (next_st.fsm == DASF_SNK_WAIT)
                     || (next_st.fsm == DASF_SNK_ATT);
    next_st.cc2_pd = next_st.cc1_pd;
    next_st.cc1_pu = (next_st.fsm == DASF_SRC_IDLE) || (next_st.fsm == DASF_SRC_TRY);
    next_st.cc2_pu = next_st.cc1_pu;
    next_st.dbg    = (next_st.fsm == DASF_SNK_ATT);
    next_st.pd     = (next_st.fsm == DASF_SNK_ATT) && orient_known;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st        <= '0;
      st.fsm    <= DASF_SNK_IDLE;
      st.cc1_pd <= 1'b1;
      st.cc2_pd <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign conn_state    = st.fsm;
  assign cc1_pulldown  = st.cc1_pd;
  assign cc2_pulldown  = st.cc2_pd;
  assign cc1_pullup    = st.cc1_pu;
  assign cc2_pullup    = st.cc2_pu;
  assign vbus_drive    = 1'b0;
  assign vconn_drive   = 1'b0;
  assign debug_connect = st.dbg;
  assign pd_enable     = st.pd;
  assign src_try_start = st.try_p;

  sequence s_fault_entry;
    !st.cc1_pd && !st.cc1_pu && !st.cc2_pd && !st.cc2_pu;
  endsequence

  chk_fault_no_term: assert property (@(posedge clk) disable iff (!rst_n)
    st.fsm == DASF_FAULT |-> s_fault_entry)
    else $error("termination present during fault reconnect");
  chk_fault_req_enter: assert property (@(posedge clk) disable iff (!rst_n)
    (fault_req && FAULT_SUPPORT && st.fsm != DASF_FAULT) |=> st.fsm == DASF_FAULT)
    else $error("fault directive not honoured");
  chk_fault_exit: assert property (@(posedge clk) disable iff (!rst_n)
    ($past(st.fsm) == DASF_FAULT && st.fsm != DASF_FAULT && !$past(fault_req))
      |-> st.fsm == idle_st)
    else $error("wrong exit from fault reconnect");
  chk_sink_pulldown: assert property (@(posedge clk) disable iff (!rst_n)
    (st.fsm == DASF_SNK_IDLE || st.fsm == DASF_SNK_WAIT) |-> st.cc1_pd && st.cc2_pd)
    else $error("sink state without pull-downs");
  chk_wait_entry: assert property (@(posedge clk) disable iff (!rst_n)
    (st.fsm == DASF_SNK_IDLE && both_up && !fault_req) |=> st.fsm == DASF_SNK_WAIT)
    else $error("attach wait not entered");
  chk_vbus_loss: assert property (@(posedge clk) disable iff (!rst_n)
    (st.fsm == DASF_SNK_ATT && !st.vb_s && !fault_req) |=> st.fsm == DASF_SNK_IDLE)
    else $error("attached kept without bus power");
  chk_dbg_attached: assert property (@(posedge clk) disable iff (!rst_n)
    debug_connect |-> st.fsm == DASF_SNK_ATT)
    else $error("debug signals connected while unattached");
  chk_pd_orient: assert property (@(posedge clk) disable iff (!rst_n)
    pd_enable |-> $past(orient_known) && st.fsm == DASF_SNK_ATT)
    else $error("messaging without orientation");
  chk_no_vconn: assert property (@(posedge clk) disable iff (!rst_n)
    !vconn_drive && !vbus_drive)
    else $error("supply driven");
  chk_attach_match: assert property (@(posedge clk) disable iff (!rst_n)
    ($past(st.fsm) == DASF_SNK_IDLE && st.fsm == DASF_SNK_WAIT) |-> $past(both_up))
    else $error("attach wait without matching pull-ups");
endmodule : dasf_attach_fsm

// file: dasf_consts.svh
// timing counts and encodings for the debug probe attach machine
`ifndef DASF_CONSTS_SVH
`define DASF_CONSTS_SVH
`define DASF_CLK_MHZ            200
`define DASF_FAULT_US           25
`define DASF_FAULT_CYC          (`DASF_FAULT_US * `DASF_CLK_MHZ)
`define DASF_SHORT_DEB_US       10
`define DASF_SHORT_DEB_CYC      (`DASF_SHORT_DEB_US * `DASF_CLK_MHZ)
`define DASF_ATTACH_DEB_US      100
`define DASF_ATTACH_DEB_CYC     (`DASF_ATTACH_DEB_US * `DASF_CLK_MHZ)
`define DASF_TOGGLE_US          75
`define DASF_SRC_SHARE_PCT      30
`define DASF_SINK_SEES_OPEN_CYC       ((`DASF_TOGGLE_US * (100 - `DASF_SRC_SHARE_PCT) * `DASF_CLK_MHZ) / 100)
`define DASF_TIMER_W            20
`define DASF_CC_OPEN            2'h0
`define DASF_CC_PULLUP          2'h1
`define DASF_CC_PULLDN          2'h2
`define DASF_ROLE_SINK          2'h0
`define DASF_ROLE_SOURCE        2'h1
`define DASF_ROLE_DUAL          2'h2
`endif

// file: dasf_pkg.sv
// types for the debug probe attach machine
package dasf_pkg;
  typedef enum logic [6:0] {
    DASF_FAULT      = 7'b000_0001,
    DASF_SNK_IDLE   = 7'b000_0010,
    DASF_SNK_WAIT   = 7'b000_0100,
    DASF_SNK_ATT    = 7'b000_1000,
    DASF_SRC_IDLE   = 7'b001_0000,
    DASF_SRC_TRY    = 7'b010_0000,
    DASF_DISABLED   = 7'b100_0000
  } dasf_state_t;
endpackage : dasf_pkg

// file: dasf_target_model.sv
// target port model presenting terminations and bus power at the receptacle
`timescale 1ns/1ps
module dasf_target_model (
  input  wire logic       clk,
  input  wire logic [1:0] term_mode,
  input  wire logic       power_on,
  output logic      [1:0] cc1_level,
  output logic      [1:0] cc2_level,
  output logic            vbus_present
);
  // mode 0 no terminations, 1 pull-up on both, 2 pull-up and pull-down
  // no supply output for the powered cable exists here
  always_ff @(posedge clk) begin
    cc1_level    <= (term_mode == 2'h0) ? 2'h0 : 2'h1;
    cc2_level    <= (term_mode == 2'h2) ? 2'h2 : term_mode;
    vbus_present <= power_on;
  end
endmodule : dasf_target_model

// file: dasf_timer.sv
// restartable down-counting timer
`timescale 1ns/1ps
`include "dasf_consts.svh"
module dasf_timer
  import dasf_pkg::*;
(
  input wire logic  clk,
  input wire logic  rst_n,
  dasf_timer_if.tmr tif
);
  typedef struct packed {
    logic [`DASF_TIMER_W-1:0] cnt;
    logic                     done;
  } dasf_tmr_t;
  dasf_tmr_t st;
  dasf_tmr_t next_st;

  always_comb begin
    next_st = st;
    if (tif.restart) begin
      next_st.cnt  = tif.limit;
      next_st.done = 1'b0;
    end else if (st.cnt != '0) begin
      next_st.cnt = st.cnt - 1'b1;
    end else begin
      next_st.done = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // registered only; the user masks a stale done in a restart cycle
  assign tif.done = st.done;
endmodule : dasf_timer

// file: dasf_timer_if.sv
// timer control between state machine and timer
`timescale 1ns/1ps
interface dasf_timer_if;
  logic        restart;
  logic [19:0] limit;
  logic        done;
  modport ctrl (output restart, output limit, input done);
  modport tmr  (input restart, input limit, output done);
endinterface : dasf_timer_if

// file: debug_accessory_sink_attach_fsm_tb_top.sv
// testbench for the sink-only attach machine against the target model
`timescale 1ns/1ps
`include "dasf_consts.svh"
module debug_accessory_sink_attach_fsm_tb_top;
  import dasf_pkg::*;
  logic        clk, rst_n, orient_known, fault_req, role_swap_req, power_on;
  logic [1:0]  term_mode, cc1_level, cc2_level;
  logic        vbus_present, cc1_pulldown, cc2_pulldown, cc1_pullup, cc2_pullup;
  logic        vbus_drive, vconn_drive, debug_connect, pd_enable, src_try_start;
  logic [6:0]  conn_state, last_state, dr_state;
  logic        dr_pu1, dr_pu2;
  logic [11:0] exp_q[$];
  int          n_errors, comparisons, w;

  dasf_target_model tgt (.clk, .term_mode, .power_on, .cc1_level, .cc2_level, .vbus_present);
  dasf_attach_fsm #(.PROBE_ROLE(`DASF_ROLE_SINK), .FAULT_CYC(8), .SHORT_DEB_CYC(8),
    .ATTACH_DEB_CYC(12), .SINK_SEES_OPEN_CYC(10)) dut (.clk, .rst_n, .cc1_level, .cc2_level,
    .vbus_present, .orient_known, .fault_req, .role_swap_req, .conn_state, .cc1_pulldown,
    .cc2_pulldown, .cc1_pullup, .cc2_pullup, .vbus_drive, .vconn_drive, .debug_connect,
    .pd_enable, .src_try_start);
  // dual-role probe on the same receptacle signals
  dasf_attach_fsm #(.PROBE_ROLE(`DASF_ROLE_DUAL), .FAULT_CYC(8), .SHORT_DEB_CYC(8),
    .ATTACH_DEB_CYC(12), .SINK_SEES_OPEN_CYC(10)) dut_dr (.clk, .rst_n, .cc1_level, .cc2_level,
    .vbus_present, .orient_known, .fault_req, .role_swap_req, .conn_state(dr_state),
    .cc1_pulldown(), .cc2_pulldown(), .cc1_pullup(dr_pu1), .cc2_pullup(dr_pu2),
    .vbus_drive(), .vconn_drive(), .debug_connect(), .pd_enable(), .src_try_start());

  function automatic logic [11:0] seen();
    return {conn_state, cc1_pulldown, cc2_pulldown, cc1_pullup, cc2_pullup, debug_connect};
  endfunction : seen

  function automatic logic [11:0] ex(input logic [6:0] s, input logic pd, input logic dbg);
    return {s, pd, pd, 2'b00, dbg};
  endfunction : ex

  task automatic check(input logic [11:0] got, input logic [11:0] want);
    comparisons++;
    if (got !== want) begin
      n_errors++;
      $display("unexpected at %0t ns: saw %h, wanted %h", $time, got, want);
    end
  endtask : check

  // note the next state and wait until the monitor has consumed it
  task automatic expect_next(input logic [11:0] e);
    exp_q.push_back(e);
    w = 0;
    while (exp_q.size() != 0 && w < 60) begin
      @(negedge clk);
      w++;
    end
    if (exp_q.size() != 0) begin
      check(12'h0, e);
      exp_q.delete();
    end
  endtask : expect_next

  task automatic end_of_test();
    $display("comparisons %0d, n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // monitor: every state change consumes the oldest note
  always @(negedge clk) begin
    if (rst_n === 1'b1 && conn_state !== last_state)
      check(seen(), (exp_q.size() != 0) ? exp_q.pop_front() : 12'hfff);
    check({9'h0, src_try_start, vconn_drive, vbus_drive}, 12'h0);
    last_state = conn_state;
  end

  initial begin
    #20000;
    n_errors++;
    end_of_test();
  end

  initial begin
    rst_n = 1'b0;
    term_mode = 2'h0;
    power_on = 1'b0;
    orient_known = 1'b0;
    fault_req = 1'b0;
    role_swap_req = 1'b0;
    last_state = DASF_SNK_IDLE;
    w = $urandom(34);
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    check(seen(), ex(DASF_SNK_IDLE, 1'b1, 1'b0));
    term_mode = 2'h2;
    role_swap_req = 1'b1;
    repeat (20) @(negedge clk);
    role_swap_req = 1'b0;
    check(seen(), ex(DASF_SNK_IDLE, 1'b1, 1'b0));
    check({dr_state, dr_pu1, dr_pu2, 3'b000}, {DASF_SRC_IDLE, 2'b11, 3'b000});
    term_mode = 2'h1;
    orient_known = 1'b1;
    expect_next(ex(DASF_SNK_WAIT, 1'b1, 1'b0));
    check({11'h0, pd_enable}, 12'h0);
    term_mode = 2'h0;
    repeat (1 + $urandom % 4) @(negedge clk);
    term_mode = 2'h1;
    repeat (12) @(negedge clk);
    term_mode = 2'h0;
    expect_next(ex(DASF_SNK_IDLE, 1'b1, 1'b0));
    check(12'(w >= 8), 12'h1);
    for (int k = 0; k < 2; k++) begin
      orient_known = 1'b0;
      role_swap_req = 1'($urandom);
      term_mode = 2'h1;
      power_on = 1'b1;
      expect_next(ex(DASF_SNK_WAIT, 1'b1, 1'b0));
      expect_next(ex(DASF_SNK_ATT, 1'b1, 1'b1));
      check(12'(w >= 12), 12'h1);
      repeat (3) @(negedge clk);
      check({11'h0, pd_enable}, 12'h0);
      orient_known = 1'b1;
      repeat (2) @(negedge clk);
      check({11'h0, pd_enable}, 12'h1);
      term_mode = 2'h0;
      power_on = 1'b0;
      if (k == 0) begin
        expect_next(ex(DASF_SNK_IDLE, 1'b1, 1'b0));
      end else begin
        fault_req = 1'b1;
        @(negedge clk);
        fault_req = 1'b0;
        expect_next(ex(DASF_FAULT, 1'b0, 1'b0));
        expect_next(ex(DASF_SNK_IDLE, 1'b1, 1'b0));
        check(12'(w >= 8), 12'h1);
        check({5'h0, dr_state}, {5'h0, DASF_SRC_IDLE});
      end
    end
    end_of_test();
  end
endmodule : debug_accessory_sink_attach_fsm_tb_top
